// file: common/tof_link_pkg.sv
// Shared constants and types for the sensor frame link
package tof_link_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam int unsigned WORDS_W       = 4;
    localparam logic [7:0]  CMD_CONFIG    = 8'h10;
    localparam logic [7:0]  CMD_START     = 8'h20;
    localparam logic [7:0]  CMD_READ      = 8'h80;
    localparam logic [3:0]  FRAME_WORDS_RST = 4'h8;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned SCLK_PERIOD_NS = 200;
    localparam int unsigned SCLK_HALF      = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned TIMER_TICK_NS  = 1000;
    localparam int unsigned TIMER_TICK_CYC = TIMER_TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        ACQ_IDLE = 1'b0,
        ACQ_RUN  = 1'b1
    } acq_state_e;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b000,
        SEQ_CFG   = 3'b001,
        SEQ_START = 3'b010,
        SEQ_WAIT  = 3'b011,
        SEQ_READ  = 3'b100
    } host_seq_e;

    typedef enum logic [2:0] {
        PH_OFF   = 3'b000,
        PH_SETUP = 3'b001,
        PH_LOW   = 3'b010,
        PH_HIGH  = 3'b011,
        PH_HOLD  = 3'b100,
        PH_GAP   = 3'b101
    } wire_phase_e;
endpackage : tof_link_pkg

// file: common/tof_link_if.sv
// Serial link and interrupt between host and sensor
`timescale 1ns/1ps
interface tof_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;
    logic measurement_done_irq;

    // Pulled high when the sensor releases the line
    assign miso_line = miso_oe ? miso : 1'b1;

    modport sensor (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso,
        output miso_oe,
        output measurement_done_irq
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso_line,
        input  measurement_done_irq
    );
endinterface : tof_link_if

// file: src/tof_sensor_end.sv
// Sensor end: serial slave, frame acquisition and result FIFO
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end
endmodule : sample_fifo

module tof_sensor_end #(
    parameter int unsigned DEPTH = tof_link_pkg::FIFO_DEPTH
) (
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    tof_link_if.sensor                       link,
    input  wire logic                        sensor_valid_i,
    input  wire logic [tof_link_pkg::DATA_W-1:0] sensor_data_i,
    output logic                             sensor_ready_o,
    output logic                             frame_active_o
);
    import tof_link_pkg::*;

    logic               sclk_s1, sclk_s2, sclk_s3;
    logic               cs_s1, cs_s2, cs_s3;
    logic               mosi_s1, mosi_s2;
    logic               sclk_rise, sclk_fall, cs_active, cs_rise;
    logic [2:0]         bit_cnt;
    logic [7:0]         rx_sh;
    logic [7:0]         tx_sh;
    logic [7:0]         cmd;
    logic               addr_seen;
    logic               byte_done;
    logic [7:0]         byte_val;
    logic               start_pend;
    logic [WORDS_W-1:0] frame_words;
    logic [WORDS_W-1:0] words_left;
    acq_state_e         state;
    logic               irq;
    logic               miso;
    logic               miso_oe;
    logic               read_pop;
    logic               frame_start;
    logic               frame_done;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [DATA_W-1:0]  fifo_out_data;

    // two-stage capture of link pins, edge detect on second stage
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_s3 <= 1'b1;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_s3   <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1   <= link.cs_n;
            cs_s2   <= cs_s1;
            cs_s3   <= cs_s2;
            mosi_s1 <= link.mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    assign cs_active = !cs_s2;
    assign cs_rise   = cs_s2 && !cs_s3;
    assign sclk_rise = cs_active && sclk_s2 && !sclk_s3;
    assign sclk_fall = cs_active && !sclk_s2 && sclk_s3;
    assign byte_done = sclk_rise && (bit_cnt == 3'h7);
    assign byte_val  = {rx_sh[6:0], mosi_s2};

    // eight-bit chunks, MSB first, first is address
    always_ff @(posedge clock_i) begin
        if (reset_i || !cs_active) begin
            bit_cnt   <= 3'h0;
            rx_sh     <= 8'h00;
            addr_seen <= 1'b0;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= byte_val;
            if (bit_cnt == 3'h7) begin
                addr_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cmd <= 8'h00;
        end else if (byte_done && !addr_seen) begin
            cmd <= byte_val;
        end
    end

    // Frame length from configuration write, clamped to buffer depth
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            frame_words <= FRAME_WORDS_RST;
        end else if (byte_done && addr_seen && cmd == CMD_CONFIG) begin
            if (byte_val > 8'(DEPTH)) begin
                frame_words <= WORDS_W'(DEPTH);
            end else begin
                frame_words <= byte_val[WORDS_W-1:0];
            end
        end
    end

    // one start command arms one frame at deselect; acquisition is idle by then, as the selection aborts any running frame
    always_ff @(posedge clock_i) begin
        if (reset_i || cs_rise) begin
            start_pend <= 1'b0;
        end else if (byte_done && !addr_seen && byte_val == CMD_START) begin
            start_pend <= 1'b1;
        end
    end

    assign frame_start = cs_rise && start_pend && (state == ACQ_IDLE);
    assign frame_done  = (state == ACQ_RUN) && (words_left == '0) && !cs_active;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state      <= ACQ_IDLE;
            words_left <= '0;
        end else begin
            case (state)
                ACQ_IDLE: begin
                    if (frame_start) begin
                        state      <= ACQ_RUN;
                        words_left <= frame_words;
                    end
                end
                ACQ_RUN: begin
                    // chip select aborts, else stop after frame
                    if (cs_active || words_left == '0) begin
                        state <= ACQ_IDLE;
                    end else if (sensor_valid_i && fifo_in_ready) begin
                        words_left <= words_left - WORDS_W'(1);
                    end
                end
                default: begin
                    state <= ACQ_IDLE;
                end
            endcase
        end
    end

    assign sensor_ready_o = (state == ACQ_RUN) && !cs_active && (words_left != '0)
                            && fifo_in_ready;
    assign frame_active_o = (state == ACQ_RUN);

    sample_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i    (clock_i),
        .reset_i    (reset_i),
        .flush_i    (frame_start),
        .in_valid_i (sensor_valid_i && sensor_ready_o),
        .in_data_i  (sensor_data_i),
        .in_ready_o (fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o (fifo_out_data),
        .out_ready_i(read_pop)
    );

    // each byte of a read, address byte included, takes one word from the buffer while one is left
    assign read_pop = byte_done && ((!addr_seen && byte_val == CMD_READ)
                      || (addr_seen && cmd == CMD_READ));

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_sh <= 8'h00;
            miso  <= 1'b1;
        end else if (read_pop) begin
            tx_sh <= fifo_out_valid ? fifo_out_data : 8'h00;
        end else if (sclk_fall) begin
            miso  <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= cs_active;
        end
    end

    // held until read address arrives; setting wins
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq <= 1'b0;
        end else if (frame_done) begin
            irq <= 1'b1;
        end else if (byte_done && !addr_seen && byte_val == CMD_READ) begin
            irq <= 1'b0;
        end
    end

    // single interrupt line and serial data output
    assign link.measurement_done_irq = irq;
    assign link.miso                 = miso;
    assign link.miso_oe              = miso_oe;
endmodule : tof_sensor_end

// file: src/tof_host_end.sv
// Host end: serial master, frame sequencing and read-out
`timescale 1ns/1ps
module tof_host_end #(
    parameter int unsigned HALF = tof_link_pkg::SCLK_HALF
) (
    input  wire logic                            clock_i,
    input  wire logic                            reset_i,
    tof_link_if.host                             link,
    input  wire logic                            start_i,
    input  wire logic [7:0]                      cfg_words_i,
    output logic                                 busy_o,
    output logic                                 rd_valid_o,
    output logic      [tof_link_pkg::DATA_W-1:0] rd_data_o,
    input  wire logic                            gpio_en_i,
    input  wire logic                            gpio_sclk_i,
    input  wire logic                            gpio_cs_n_i,
    input  wire logic                            gpio_mosi_i,
    output logic                                 gpio_miso_o,
    output logic      [31:0]                     timer_o
);
    import tof_link_pkg::*;

    host_seq_e   seq;
    wire_phase_e phase;
    logic [7:0]  words;
    logic [7:0]  cnt;
    logic [2:0]  bit_cnt;
    logic [8:0]  byte_idx;
    logic [8:0]  nbytes;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  addr;
    logic [7:0]  data_byte;
    logic        half_end;
    logic        xfer_done;
    logic        active;
    logic        sclk, cs_n, mosi;
    logic        miso_s1, miso_s2, irq_s1, irq_s2;
    logic [7:0]  tick_cnt;

    // Pin inputs pass two stages
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            miso_s1 <= 1'b1;
            miso_s2 <= 1'b1;
            irq_s1  <= 1'b0;
            irq_s2  <= 1'b0;
        end else begin
            miso_s1 <= link.miso_line;
            miso_s2 <= miso_s1;
            irq_s1  <= link.measurement_done_irq;
            irq_s2  <= irq_s1;
        end
    end

    assign half_end  = cnt == 8'(HALF - 1);
    assign xfer_done = (phase == PH_GAP) && half_end;
    assign active    = (seq == SEQ_CFG) || (seq == SEQ_START) || (seq == SEQ_READ);
    assign busy_o    = seq != SEQ_IDLE;

    always_comb begin
        case (seq)
            SEQ_CFG: begin
                addr   = CMD_CONFIG;
                nbytes = 9'h002;
            end
            SEQ_START: begin
                addr   = CMD_START;
                nbytes = 9'h001;
            end
            default: begin
                addr   = CMD_READ;
                nbytes = 9'(words) + 9'h001;
            end
        endcase
        data_byte = (seq == SEQ_CFG) ? words : 8'h00;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            seq   <= SEQ_IDLE;
            words <= 8'h00;
        end else begin
            case (seq)
                SEQ_IDLE: begin
                    if (start_i && !gpio_en_i) begin
                        seq   <= SEQ_CFG;
                        words <= (cfg_words_i > 8'(FIFO_DEPTH)) ? 8'(FIFO_DEPTH)
                                                               : cfg_words_i;
                    end
                end
                SEQ_CFG: if (xfer_done) begin
                    seq <= SEQ_START;
                end
                SEQ_START: if (xfer_done) begin
                    seq <= SEQ_WAIT;
                end
                SEQ_WAIT: if (irq_s2) begin
                    seq <= SEQ_READ;
                end
                SEQ_READ: if (xfer_done) begin
                    seq <= SEQ_IDLE;
                end
                default: begin
                    seq <= SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || phase == PH_OFF || half_end) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // clock idles high; drive on fall, sample as high half ends
    // address byte first, data bytes MSB first
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            phase      <= PH_OFF;
            sclk       <= 1'b1;
            cs_n       <= 1'b1;
            mosi       <= 1'b1;
            bit_cnt    <= 3'h0;
            byte_idx   <= 9'h000;
            tx_sh      <= 8'h00;
            rx_sh      <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_data_o  <= '0;
        end else begin
            rd_valid_o <= 1'b0;
            case (phase)
                PH_OFF: if (active) begin
                    phase    <= PH_SETUP;
                    cs_n     <= 1'b0;
                    bit_cnt  <= 3'h0;
                    byte_idx <= 9'h000;
                    tx_sh    <= addr;
                end
                PH_SETUP: if (half_end) begin
                    phase <= PH_LOW;
                    sclk  <= 1'b0;
                    mosi  <= tx_sh[7];
                end
                PH_LOW: if (half_end) begin
                    phase <= PH_HIGH;
                    sclk  <= 1'b1;
                end
                PH_HIGH: if (half_end) begin
                    rx_sh   <= {rx_sh[6:0], miso_s2};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        if (seq == SEQ_READ && byte_idx != 9'h000) begin
                            rd_valid_o <= 1'b1;
                            rd_data_o  <= {rx_sh[6:0], miso_s2};
                        end
                        if (byte_idx == nbytes - 9'h001) begin
                            phase <= PH_HOLD;
                        end else begin
                            byte_idx <= byte_idx + 9'h001;
                            tx_sh    <= data_byte;
                            mosi     <= data_byte[7];
                            sclk     <= 1'b0;
                            phase    <= PH_LOW;
                        end
                    end else begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        mosi  <= tx_sh[6];
                        sclk  <= 1'b0;
                        phase <= PH_LOW;
                    end
                end
                PH_HOLD: if (half_end) begin
                    cs_n  <= 1'b1;
                    phase <= PH_GAP;
                end
                PH_GAP: if (half_end) begin
                    phase <= PH_OFF;
                end
                default: begin
                    phase <= PH_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            link.sclk   <= 1'b1;
            link.cs_n   <= 1'b1;
            link.mosi   <= 1'b1;
            gpio_miso_o <= 1'b1;
        end else begin
            link.sclk   <= gpio_en_i ? gpio_sclk_i : sclk;
            link.cs_n   <= gpio_en_i ? gpio_cs_n_i : cs_n;
            link.mosi   <= gpio_en_i ? gpio_mosi_i : mosi;
            gpio_miso_o <= miso_s2;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tick_cnt <= 8'h00;
            timer_o  <= 32'h0000_0000;
        end else if (tick_cnt == 8'(TIMER_TICK_CYC - 1)) begin
            tick_cnt <= 8'h00;
            timer_o  <= timer_o + 32'h0000_0001;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end
endmodule : tof_host_end

// file: verif/tof_link_sva.sv
// Checker for the serial link and interrupt between both ends
`timescale 1ns/1ps
module tof_link_sva (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_line,
    input wire logic measurement_done_irq
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    logic [7:0] rise_cnt;
    logic       sclk_q;

    // Rising clock edges within one selection
    always_ff @(posedge clock_i) begin
        sclk_q <= sclk;
    end
    always_ff @(posedge clock_i) begin
        if (reset_i || cs_n) begin
            rise_cnt <= 8'h00;
        end else if (sclk && !sclk_q) begin
            rise_cnt <= rise_cnt + 8'h01;
        end
    end

    property p_sclk_idle;
        cs_n && $past(cs_n) |-> sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock not high while idle");
    property p_sclk_framed;
        $changed(sclk) |-> !cs_n;
    endproperty
    a_sclk_framed: assert property (p_sclk_framed) else $error("clock moved unselected");
    property p_mosi_on_fall;
        !cs_n && $past(!cs_n) && $changed(mosi) |-> $fell(sclk);
    endproperty
    a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("data moved off falling edge");
    property p_low_half;
        $fell(sclk) |-> (!sclk)[*4] ##1 sclk;
    endproperty
    a_low_half: assert property (p_low_half) else $error("clock low half wrong");
    property p_whole_bytes;
        $rose(cs_n) |-> rise_cnt[2:0] == 3'h0;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte on link");
    property p_miso_released;
        cs_n[*4] |-> !miso_oe && miso_line;
    endproperty
    a_miso_released: assert property (p_miso_released) else $error("data out not released");
    property p_irq_held;
        measurement_done_irq && cs_n |=> measurement_done_irq;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("interrupt dropped early");
    property p_irq_clear;
        $fell(cs_n) && measurement_done_irq |-> ##[1:90] !measurement_done_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");
    property p_irq_rise;
        $rose(measurement_done_irq) |-> cs_n;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt while selected");
endmodule : tof_link_sva

// file: verif/testbench.sv
// Testbench joining host end and sensor end over the link
`timescale 1ns/1ps
module testbench;
    import tof_link_pkg::*;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        start_i = 1'b0;
    logic [7:0]  cfg_words = 8'h00;
    logic        busy;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        sens_valid = 1'b1;
    logic        sens_ready;
    logic        frame_active;
    logic        took = 1'b0;
    logic        gpio_en = 1'b0;
    logic        gpio_cs_n = 1'b1;
    logic        gpio_sclk = 1'b1;
    logic        gpio_mosi = 1'b1;
    logic        gpio_miso;
    localparam logic [7:0] GPIO_PAT = 8'h5a;
    logic [31:0] timer;
    logic [31:0] t0;
    logic [7:0]  widx = 8'h00;
    logic [7:0]  sh = 8'h00;
    logic [7:0]  got[$];
    logic [7:0]  addr[$];
    logic [7:0]  exp_cmd[3] = '{CMD_CONFIG, CMD_START, CMD_READ};
    int          nb = 0;
    int          cycles = 0;
    int          err_total = 0;
    int          check_count = 0;
    wire  [7:0]  sens_data = 8'ha0 + widx;

    tof_link_if link ();
    tof_host_end u_tof_host_end (.clock_i(clock_i), .reset_i(reset_i), .link(link.host),
        .start_i(start_i), .cfg_words_i(cfg_words), .busy_o(busy), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .gpio_en_i(gpio_en), .gpio_sclk_i(gpio_sclk),
        .gpio_cs_n_i(gpio_cs_n), .gpio_mosi_i(gpio_mosi), .gpio_miso_o(gpio_miso),
        .timer_o(timer));
    tof_sensor_end u_tof_sensor_end (.clock_i(clock_i), .reset_i(reset_i), .link(link.sensor),
        .sensor_valid_i(sens_valid), .sensor_data_i(sens_data), .sensor_ready_o(sens_ready),
        .frame_active_o(frame_active));
    tof_link_sva u_tof_link_sva (.clock_i(clock_i), .reset_i(reset_i), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
        .miso_line(link.miso_line), .measurement_done_irq(link.measurement_done_irq));

    always #12.5 clock_i = ~clock_i;

    // Word feed, read-out capture and hang limit
    always @(posedge clock_i) begin
        cycles++;
        took <= sens_valid & sens_ready;
        if (rd_valid === 1'b1) got.push_back(rd_data);
        if (cycles >= 60000) begin
            err_total++;
            tally_and_finish();
        end
    end
    always @(negedge clock_i) if (took) widx <= widx + 8'h01;

    // First byte of each transfer seen on the wire
    always @(posedge link.sclk) begin
        if (link.cs_n === 1'b0) begin
            sh = {sh[6:0], link.mosi};
            nb++;
            if (nb == 8) addr.push_back(sh);
        end
    end
    always @(negedge link.cs_n) nb = 0;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("TB: %0d checks, %0d mismatches", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Mode 0 plain, 1 stalled feed, 2 abort by select
    task automatic run_frame(input logic [7:0] n, input int mode);
        logic [7:0] base;
        int i;
        base = widx;
        got.delete();
        addr.delete();
        sens_valid = (mode == 0);
        cfg_words = n;
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        if (mode != 0) begin
            for (i = 0; i < 2000 && frame_active !== 1'b1; i++) @(negedge clock_i);
            repeat (100) @(negedge clock_i);
            check(frame_active, 1'b1, "frame held");
            check(link.measurement_done_irq, 1'b0, "early irq");
        end
        if (mode == 2) begin
            gpio_en = 1'b1;
            gpio_cs_n = 1'b0;
            repeat (8) @(negedge clock_i);
            check(link.cs_n, 1'b0, "gpio select");
            check(frame_active, 1'b0, "abort");
            sens_valid = 1'b1;
            repeat (50) @(negedge clock_i);
            check(widx, base, "words after abort");
            check(link.measurement_done_irq, 1'b0, "irq after abort");
            // Bit-banged byte through the general-purpose pins
            for (i = 7; i >= 0; i--) begin
                gpio_sclk = 1'b0;
                gpio_mosi = GPIO_PAT[i];
                repeat (4) @(negedge clock_i);
                gpio_sclk = 1'b1;
                repeat (4) @(negedge clock_i);
            end
            check(sh, GPIO_PAT, "gpio bits on wire");
            check(link.measurement_done_irq, 1'b0, "irq after gpio bits");
            gpio_cs_n = 1'b1;
            gpio_mosi = 1'b1;
            repeat (8) @(negedge clock_i);
            check(link.cs_n, 1'b1, "gpio release");
            check(gpio_miso, 1'b1, "gpio data in released");
            gpio_en = 1'b0;
            $display("TB: abort test done");
            return;
        end
        sens_valid = 1'b1;
        for (i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clock_i);
        check(got.size(), n, "byte count");
        for (i = 0; i < got.size(); i++) check(got[i], 8'ha0 + base + i, "byte");
        check(addr.size(), 3, "transfers");
        for (i = 0; i < 3 && i < addr.size(); i++) check(addr[i], exp_cmd[i], "address");
        check(link.measurement_done_irq, 1'b0, "irq after read");
        repeat (200) @(negedge clock_i);
        check(widx, base + n, "no self restart");
        check(frame_active, 1'b0, "idle after frame");
        $display("TB: frame of %0d words done", n);
    endtask : run_frame

    initial begin
        repeat (10) @(negedge clock_i);
        reset_i = 1'b0;
        @(negedge clock_i);
        check(link.cs_n, 1'b1, "select idle");
        check(link.sclk, 1'b1, "clock idle");
        t0 = timer;
        repeat (TIMER_TICK_CYC * 3) @(negedge clock_i);
        check(timer - t0, 32'h3, "timer ticks");
        $display("TB: timer test done");
        run_frame(8'h01, 0);
        run_frame(8'h08, 0);
        run_frame(8'h00, 0);
        run_frame(8'h03, 1);
        run_frame(8'h04, 2);
        reset_i = 1'b1;
        repeat (2) @(negedge clock_i);
        reset_i = 1'b0;
        @(negedge clock_i);
        run_frame(8'h02, 0);
        tally_and_finish();
    end
endmodule : testbench
